// >>> rtl/pwm_cycle_pkg.sv
// Functional notes
// - reload select routes compare accesses to reload
// - reload values used only in 9-11 bit
// - interrupt request equals flag and enable
// - flag sets on selected counter bit overflow
// - flag set by hardware or software only
// - unused bits read zero, writes ignored
// - select 00/01/10 gives 8/9/10 bit cycle
// - wide channels ignore the shared cycle length
// - configuration register resets to all zero
// - wide enable picks 16-bit cycle over shared
package pwm_cycle_pkg;
    localparam logic [7:0] CFG_ADDR      = 8'h00_F4;
    localparam logic [7:0] CFG_RESET     = 8'h00_00;
    localparam int         RELOAD_SEL_BIT = 7;
    localparam int         OVF_INT_EN_BIT = 6;
    localparam int         OVF_FLAG_BIT   = 5;
    localparam int         LEN_SEL_LSB    = 0;
    localparam int         LEN_SEL_W      = 2;
    localparam int         COUNT_W        = 16;
    localparam int         NUM_CHANNELS   = 5;
    localparam logic [1:0] LEN_8         = 2'h0;
    localparam logic [1:0] LEN_9         = 2'h1;
    localparam logic [1:0] LEN_10        = 2'h2;
    localparam logic [1:0] LEN_11        = 2'h3;
    localparam int         BASE_LEN      = 8;
endpackage : pwm_cycle_pkg

// >>> rtl/pwm_cycle_length_config.sv
`timescale 1ns/10ps
module pwm_cycle_length_config #(
    parameter int CHANNELS = pwm_cycle_pkg::NUM_CHANNELS
) (
    input  wire logic                                 clk_in,
    input  wire logic                                 rst_in,
    input  wire logic [7:0]                           sfr_addr_in,
    input  wire logic                                 sfr_wr_in,
    input  wire logic                                 sfr_rd_in,
    input  wire logic [7:0]                           sfr_wdata_in,
    output logic      [7:0]                           sfr_rdata_out,
    input  wire logic                                 cmp_wr_in,
    input  wire logic                                 cmp_rd_in,
    output logic                                      capcmp_wr_out,
    output logic                                      capcmp_rd_out,
    output logic                                      reload_wr_out,
    output logic                                      reload_rd_out,
    input  wire logic [pwm_cycle_pkg::COUNT_W-1:0]    main_counter_in,
    input  wire logic [CHANNELS-1:0]                  pwm_mode_in,
    input  wire logic [CHANNELS-1:0]                  wide_pwm_enable_in,
    output logic      [CHANNELS-1:0]                  chan_reload_use_out,
    output logic      [CHANNELS-1:0]                  chan_cycle_end_out,
    output logic      [1:0]                           cycle_len_sel_out,
    output logic                                      cycle_ovf_flag_out,
    output logic                                      cycle_irq_out
);
    import pwm_cycle_pkg::*;

    typedef struct packed {
        logic                 reload_reg_select;
        logic                 cycle_ovf_int_en;
        logic                 cycle_ovf_flag;
        logic [1:0]           cycle_len_sel;
        logic [COUNT_W-1:0]   prev_count;
        logic                 prev_valid;
        logic [7:0]           rdata;
    } state_s;

    state_s st;
    state_s next_st;

    logic             cfg_hit;
    logic [7:0]       cfg_value;
    logic [3:0]       sel_bits;
    logic [10:0]      low_mask;
    logic             short_ovf;
    logic             wide_ovf;

    assign cfg_hit = sfr_addr_in == CFG_ADDR;

    // unused bits 4:2 always read back as zero
    assign cfg_value = {st.reload_reg_select, st.cycle_ovf_int_en, st.cycle_ovf_flag,
                        3'b000, st.cycle_len_sel};

    // cycle length in bits; 11 maps to eleven bits like the other codes
    always_comb begin
        unique case (st.cycle_len_sel)
            LEN_8:  sel_bits = 4'(BASE_LEN);
            LEN_9:  sel_bits = 4'(BASE_LEN + 1);
            LEN_10: sel_bits = 4'(BASE_LEN + 2);
            LEN_11: sel_bits = 4'(BASE_LEN + 3);
        endcase
    end

    assign low_mask = 11'((12'h0_001 << sel_bits) - 12'h0_001);

    // the low bits roll from all ones to zero: an overflow out of the chosen bit
    assign short_ovf = st.prev_valid
                     && ((st.prev_count[10:0] & low_mask) == low_mask)
                     && ((main_counter_in[10:0] & low_mask) == 11'h000);
    assign wide_ovf  = st.prev_valid
                     && (st.prev_count == {COUNT_W{1'b1}})
                     && (main_counter_in == '0);

    always_comb begin
        next_st            = st;
        next_st.prev_count = main_counter_in;
        next_st.prev_valid = 1'b1;
        next_st.rdata      = (sfr_rd_in && cfg_hit) ? cfg_value : 8'h00;
        if (sfr_wr_in && cfg_hit) begin
            next_st.reload_reg_select = sfr_wdata_in[RELOAD_SEL_BIT];
            next_st.cycle_ovf_int_en  = sfr_wdata_in[OVF_INT_EN_BIT];
            next_st.cycle_ovf_flag    = sfr_wdata_in[OVF_FLAG_BIT];
            next_st.cycle_len_sel     = sfr_wdata_in[LEN_SEL_LSB +: LEN_SEL_W];
        end
        // hardware only sets; a same-cycle software clear loses to the event
        if (short_ovf) begin
            next_st.cycle_ovf_flag = 1'b1;
        end
        if (rst_in) begin
            next_st                   = '0;
            next_st.reload_reg_select = CFG_RESET[RELOAD_SEL_BIT];
            next_st.cycle_ovf_int_en  = CFG_RESET[OVF_INT_EN_BIT];
            next_st.cycle_ovf_flag    = CFG_RESET[OVF_FLAG_BIT];
            next_st.cycle_len_sel     = CFG_RESET[LEN_SEL_LSB +: LEN_SEL_W];
        end
    end

    always_ff @(posedge clk_in) begin
        st <= next_st;
    end

    assign sfr_rdata_out      = st.rdata;
    assign cycle_len_sel_out  = st.cycle_len_sel;
    assign cycle_ovf_flag_out = st.cycle_ovf_flag;
    assign cycle_irq_out      = st.cycle_ovf_flag & st.cycle_ovf_int_en;

    // compare-address strobes go to exactly one register bank
    assign capcmp_wr_out = cmp_wr_in & ~st.reload_reg_select;
    assign capcmp_rd_out = cmp_rd_in & ~st.reload_reg_select;
    assign reload_wr_out = cmp_wr_in &  st.reload_reg_select;
    assign reload_rd_out = cmp_rd_in &  st.reload_reg_select;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            // reload only matters for 9..11 bit cycles of non-wide pwm channels
            assign chan_reload_use_out[ch] = pwm_mode_in[ch] && !wide_pwm_enable_in[ch]
                                           && (st.cycle_len_sel != LEN_8);
            assign chan_cycle_end_out[ch]  = pwm_mode_in[ch]
                                           && (wide_pwm_enable_in[ch] ? wide_ovf : short_ovf);

            // a channel outside pwm mode must never see the shared cycle
            a_chan_idle: assert property (@(posedge clk_in) disable iff (rst_in)
                !pwm_mode_in[ch] |-> (!chan_cycle_end_out[ch] && !chan_reload_use_out[ch]))
                else $error("idle channel shows pwm activity");
            a_chan_short: assert property (@(posedge clk_in) disable iff (rst_in)
                (pwm_mode_in[ch] && !wide_pwm_enable_in[ch]) |-> (chan_cycle_end_out[ch] == short_ovf))
                else $error("narrow channel missed shared cycle end");
        end
    endgenerate

    a_reset_zero: assert property (@(posedge clk_in) rst_in |=> (cfg_value == CFG_RESET))
        else $error("config not zero after reset");
    a_unused_zero: assert property (@(posedge clk_in) disable iff (rst_in) cfg_value[4:2] == 3'b000)
        else $error("unused config bits not zero");
    a_flag_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
        (st.cycle_ovf_flag && !(sfr_wr_in && cfg_hit)) |=> st.cycle_ovf_flag)
        else $error("overflow flag cleared by hardware");
    a_ovf_sets_flag: assert property (@(posedge clk_in) disable iff (rst_in)
        short_ovf |=> st.cycle_ovf_flag)
        else $error("overflow did not set flag");
    a_irq_gate: assert property (@(posedge clk_in) disable iff (rst_in)
        cycle_irq_out == (cycle_ovf_flag_out && cfg_value[OVF_INT_EN_BIT]))
        else $error("interrupt request mismatch");
    a_route_excl: assert property (@(posedge clk_in) disable iff (rst_in)
        cmp_wr_in |-> (reload_wr_out == cfg_value[RELOAD_SEL_BIT]) && (capcmp_wr_out != reload_wr_out))
        else $error("compare write misrouted");
    a_len_nine: assert property (@(posedge clk_in) disable iff (rst_in)
        (st.cycle_len_sel == LEN_9 && st.prev_count[8:0] == 9'h1FF && main_counter_in[8:0] == 9'h000
         && st.prev_valid) |-> short_ovf)
        else $error("9-bit overflow missed");
    a_len_eleven: assert property (@(posedge clk_in) disable iff (rst_in)
        (st.cycle_len_sel == LEN_11 && short_ovf) |-> main_counter_in[10:0] == 11'h000)
        else $error("11-bit overflow at wrong count");
    a_wide_ignores: assert property (@(posedge clk_in) disable iff (rst_in)
        (pwm_mode_in[0] && wide_pwm_enable_in[0]) |-> !chan_reload_use_out[0]
        && (chan_cycle_end_out[0] == wide_ovf))
        else $error("wide channel used shared cycle");
    a_reload_eight: assert property (@(posedge clk_in) disable iff (rst_in)
        (st.cycle_len_sel == LEN_8) |-> chan_reload_use_out == '0)
        else $error("reload used in 8-bit cycle");
    a_write_read: assert property (@(posedge clk_in) disable iff (rst_in)
        (sfr_wr_in && cfg_hit && !short_ovf) ##1 (sfr_rd_in && cfg_hit && !sfr_wr_in && !short_ovf)
        |=> sfr_rdata_out == ($past(sfr_wdata_in, 2) & 8'h00_E3))
        else $error("readback differs from write");
    a_route_rd: assert property (@(posedge clk_in) disable iff (rst_in)
        cmp_rd_in |-> (reload_rd_out == st.reload_reg_select) && (capcmp_rd_out == !st.reload_reg_select))
        else $error("compare read misrouted");
    a_route_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        (!cmp_wr_in && !cmp_rd_in) |-> !(capcmp_wr_out || capcmp_rd_out || reload_wr_out || reload_rd_out))
        else $error("routing strobe without access");
    a_len_eight: assert property (@(posedge clk_in) disable iff (rst_in)
        (st.cycle_len_sel == LEN_8 && st.prev_valid && st.prev_count[7:0] == 8'hFF
         && main_counter_in[7:0] == 8'h00) |-> short_ovf)
        else $error("8-bit overflow missed");
    a_len_ten: assert property (@(posedge clk_in) disable iff (rst_in)
        (st.cycle_len_sel == LEN_10 && st.prev_valid && st.prev_count[9:0] == 10'h3FF
         && main_counter_in[9:0] == 10'h000) |-> short_ovf)
        else $error("10-bit overflow missed");
    a_len_eleven_hit: assert property (@(posedge clk_in) disable iff (rst_in)
        (st.cycle_len_sel == LEN_11 && st.prev_valid && st.prev_count[10:0] == 11'h7FF
         && main_counter_in[10:0] == 11'h000) |-> short_ovf)
        else $error("11-bit overflow missed");
    a_nine_mid: assert property (@(posedge clk_in) disable iff (rst_in)
        (st.cycle_len_sel == LEN_9 && main_counter_in[8:0] != 9'h000) |-> !short_ovf)
        else $error("9-bit overflow at wrong count");
    a_sw_set: assert property (@(posedge clk_in) disable iff (rst_in)
        (sfr_wr_in && cfg_hit && sfr_wdata_in[OVF_FLAG_BIT]) |=> st.cycle_ovf_flag)
        else $error("software set of flag lost");
    a_irq_masked: assert property (@(posedge clk_in) disable iff (rst_in)
        !st.cycle_ovf_int_en |-> !cycle_irq_out)
        else $error("masked flag raised a request");
    a_rdata_idle: assert property (@(posedge clk_in) disable iff (rst_in)
        !(sfr_rd_in && cfg_hit) |=> (sfr_rdata_out == 8'h00))
        else $error("read data without a config read");
    a_other_addr: assert property (@(posedge clk_in) disable iff (rst_in)
        (!(sfr_wr_in && cfg_hit) && !short_ovf) |=> $stable(cfg_value))
        else $error("config changed without a write");

endmodule : pwm_cycle_length_config

// >>> tb/pwm_cycle_length_config_bench.sv
`timescale 1ns/10ps
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin error_cnt++; $display("unexpected at %0t: got %h want %h", $time, act, exp); end end
module pwm_cycle_length_config_bench;
    import pwm_cycle_pkg::*;
    logic                    clk_in = 1'b0, rst_in, sfr_wr_in, sfr_rd_in, cmp_wr_in, cmp_rd_in;
    logic [7:0]              sfr_addr_in, sfr_wdata_in, sfr_rdata_out, d, e;
    logic [COUNT_W-1:0]      main_counter_in;
    logic [NUM_CHANNELS-1:0] pwm_mode_in, wide_pwm_enable_in, chan_reload_use_out, chan_cycle_end_out;
    logic [1:0]              cycle_len_sel_out;
    logic                    capcmp_wr_out, capcmp_rd_out, reload_wr_out, reload_rd_out;
    logic                    cycle_ovf_flag_out, cycle_irq_out;
    int                      error_cnt = 0, check_count = 0, n;
    pwm_cycle_length_config #(.CHANNELS(NUM_CHANNELS)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
        .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
        .sfr_rdata_out(sfr_rdata_out), .cmp_wr_in(cmp_wr_in), .cmp_rd_in(cmp_rd_in),
        .capcmp_wr_out(capcmp_wr_out), .capcmp_rd_out(capcmp_rd_out), .reload_wr_out(reload_wr_out),
        .reload_rd_out(reload_rd_out), .main_counter_in(main_counter_in), .pwm_mode_in(pwm_mode_in),
        .wide_pwm_enable_in(wide_pwm_enable_in), .chan_reload_use_out(chan_reload_use_out),
        .chan_cycle_end_out(chan_cycle_end_out), .cycle_len_sel_out(cycle_len_sel_out),
        .cycle_ovf_flag_out(cycle_ovf_flag_out), .cycle_irq_out(cycle_irq_out));
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    task automatic report_and_stop;
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    // all tasks enter and leave at a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        sfr_addr_in = a;
        sfr_wdata_in = v;
        sfr_wr_in = 1'b1;
        @(negedge clk_in);
        sfr_wr_in = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr_in = a;
        sfr_rd_in = 1'b1;
        @(negedge clk_in);
        sfr_rd_in = 1'b0;
        `CHK(sfr_rdata_out, exp)
    endtask : rd
    function automatic logic [7:0] expect_read(input logic [7:0] w);
        return w & 8'hE3;
    endfunction : expect_read
    task automatic step(input int v);
        main_counter_in = v[COUNT_W-1:0];
        @(negedge clk_in);
    endtask : step
    initial begin
        #(40 * 2000);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {rst_in, sfr_wr_in, sfr_rd_in, cmp_wr_in, cmp_rd_in} = 5'b1_0000;
        {sfr_addr_in, sfr_wdata_in, main_counter_in, pwm_mode_in, wide_pwm_enable_in} = '0;
        void'($urandom(26));
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        rd(CFG_ADDR, CFG_RESET);
        `CHK({cycle_irq_out, cycle_ovf_flag_out, cycle_len_sel_out}, 4'h0)
        for (int i = 0; i < 26; i++) begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h1C : 8'($urandom);
            e = expect_read(d);
            wr(CFG_ADDR, d);
            wr(8'hF5, ~d);
            {pwm_mode_in, wide_pwm_enable_in} = 10'($urandom);
            {cmp_wr_in, cmp_rd_in} = 2'($urandom);
            rd(CFG_ADDR, e);
            `CHK(cycle_len_sel_out, e[1:0])
            `CHK(cycle_ovf_flag_out, e[OVF_FLAG_BIT])
            `CHK(cycle_irq_out, e[OVF_FLAG_BIT] & e[OVF_INT_EN_BIT])
            `CHK({reload_wr_out, reload_rd_out, capcmp_wr_out, capcmp_rd_out}, {cmp_wr_in, cmp_rd_in, cmp_wr_in, cmp_rd_in} & {{2{e[7]}}, {2{~e[7]}}})
            `CHK(chan_reload_use_out, pwm_mode_in & ~wide_pwm_enable_in & {NUM_CHANNELS{e[1:0] != LEN_8}})
        end
        rd(8'hF5, 8'h00);
        {cmp_wr_in, cmp_rd_in} = '0;
        pwm_mode_in = '1;
        wide_pwm_enable_in = 5'h01;
        for (int s = 0; s < 4; s++) begin
            n = BASE_LEN + s;
            wr(CFG_ADDR, 8'h40 | 8'(s));
            step((1 << (n - 1)) - 1);
            step(1 << (n - 1));
            step(1 << (n - 1));
            `CHK(cycle_ovf_flag_out, 1'b0)
            step((1 << n) - 1);
            main_counter_in = 16'(1 << n);
            #1 `CHK(chan_cycle_end_out, 5'h1E)
            @(negedge clk_in);
            step(1 << n);
            `CHK({cycle_ovf_flag_out, cycle_irq_out}, 2'b11)
            step(0);
            repeat (3) @(negedge clk_in);
            `CHK(cycle_ovf_flag_out, 1'b1)
            wr(CFG_ADDR, 8'(s));
            `CHK({cycle_ovf_flag_out, cycle_irq_out}, 2'b00)
        end
        step(16'hFFFF);
        main_counter_in = 16'h0000;
        #1 `CHK(chan_cycle_end_out, 5'h1F)
        @(negedge clk_in);
        report_and_stop();
    end
endmodule : pwm_cycle_length_config_bench
